// *** logic/shwd_map.svh ***
// offsets, field positions, reset values and timing figures of the watchdog
// assumes inclusion by bare name from the watchdog module
`ifndef SHWD_MAP_SVH
`define SHWD_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SHWD_SETUP_ADDR 5'h0f
`define SHWD_SETUP_RESET 22'h0f0009
`define SHWD_PSEL_MSB 3
`define SHWD_PSEL_LSB 0
`define SHWD_EN_BIT 6
`define SHWD_RESTART_CMD_BIT 8
`define SHWD_SOFT_RST_BIT 9
`define SHWD_CLR_OUT_BIT 10
`define SHWD_FAULT_STAT_BIT 21
`define SHWD_ADDR_MSB 20
`define SHWD_ADDR_LSB 16
`define SHWD_RSVD_RO_MASK 16'hf800
`define SHWD_PSEL_DEFAULT 4'h9

// ----------------------------------------
// timing
// ----------------------------------------
`define SHWD_CLK_PERIOD_NS 20
`define SHWD_NS_PER_MS 1000000
`define SHWD_T0_MS 1
`define SHWD_T1_MS 5
`define SHWD_T2_MS 10
`define SHWD_T3_MS 25
`define SHWD_T4_MS 50
`define SHWD_T5_MS 100
`define SHWD_T6_MS 250
`define SHWD_T7_MS 500
`define SHWD_T8_MS 750
`define SHWD_T9_MS 1000
`define SHWD_T10_MS 2000

`endif

// *** logic/shwd_pkg.sv ***
// types shared by the serial host watchdog
// assumes shwd_map.svh sits on the include path
package shwd_pkg;

  // ----------------------------------------
  // decoded serial command, from the frame decoder
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [15:0] data;
  } shwd_cmd_t;

  // ----------------------------------------
  // response pulses toward the output path
  // ----------------------------------------
  typedef struct packed {
    logic load;
    logic [15:0] code;
    logic soft_reset;
  } shwd_resp_t;

  typedef enum logic [2:0] {
    SHWD_OFF = 3'b001,
    SHWD_RUN = 3'b010,
    SHWD_TRIP = 3'b100
  } shwd_state_t;

endpackage : shwd_pkg

// *** logic/shwd_watchdog.sv ***
// watchdog that watches serial host activity inside the output converter
// assumes commands arrive already decoded and checked, on core_clk
// assumes the fault pin level comes straight from the pad, unsynchronised
// limitation: a period change applies at once, but the setup write that
//   makes it also restarts the count, so the new period runs in full from zero
// limitation: the fault pin is taken as idle high; its synchroniser
//   resets to that level so no false status bit follows reset
// trade-off: the counter is 32 bits wide, ample for two seconds at the
//   core clock, at the cost of a wide compare
// the flag clear is a plain pulse; this block keeps no clear register
`timescale 1ns/100ps
`include "shwd_map.svh"

module shwd_watchdog
  import shwd_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `SHWD_NS_PER_MS / `SHWD_CLK_PERIOD_NS
) (
  input wire logic core_clk, // 50 MHz core clock
  input wire logic rstn, // synchronous reset, active low
  input wire shwd_cmd_t cmd, // decoded serial command
  input wire logic fault_pin_level, // pad level of the fault pin
  input wire logic flag_clear, // host clears the fault flag
  input wire logic [15:0] clear_code, // stored clear code
  output logic [21:0] rd_data, // readback word of the setup register
  output shwd_resp_t resp, // clear and reset pulses
  output logic wd_fault_flag, // sticky watchdog fault flag
  output logic wd_running // timer is counting
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [15:0] CFG_RESET = 16'(`SHWD_SETUP_RESET);

  // timer state
  shwd_state_t st_q;
  shwd_state_t st_d;
  // setup register
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  // period counter
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  // fault flag
  logic flag_q;
  logic flag_d;
  // expiry responses
  shwd_resp_t resp_q;
  shwd_resp_t resp_d;
  // readback word
  logic [21:0] rd_q;
  logic [21:0] rd_d;
  // fault pin synchroniser
  logic pin_s1_q;
  logic pin_s1_d;
  logic pin_s2_q;
  logic pin_s2_d;
  // command qualification and expiry
  logic setup_wr;
  logic kick;
  logic expire;
  logic [31:0] limit;

  // ----------------------------------------
  // period decode
  // ----------------------------------------
  function automatic logic [31:0] period_ms(input logic [3:0] sel);
    logic [31:0] ms;
    ms = 32'(`SHWD_T9_MS);
    case (sel)
      4'h0: ms = 32'(`SHWD_T0_MS);
      4'h1: ms = 32'(`SHWD_T1_MS);
      4'h2: ms = 32'(`SHWD_T2_MS);
      4'h3: ms = 32'(`SHWD_T3_MS);
      4'h4: ms = 32'(`SHWD_T4_MS);
      4'h5: ms = 32'(`SHWD_T5_MS);
      4'h6: ms = 32'(`SHWD_T6_MS);
      4'h7: ms = 32'(`SHWD_T7_MS);
      4'h8: ms = 32'(`SHWD_T8_MS);
      4'ha: ms = 32'(`SHWD_T10_MS);
      default: ms = 32'(`SHWD_T9_MS);
    endcase
    return ms;
  endfunction : period_ms

  // milliseconds to core cycles; a huge MS_CYCLES would wrap silently
  function automatic logic [31:0] period_cycles(input logic [3:0] sel);
    return 32'(period_ms(sel) * MS_CYCLES);
  endfunction : period_cycles

  // ----------------------------------------
  // fault pin synchroniser
  // ----------------------------------------
  always_comb begin
    pin_s1_d = fault_pin_level;
    pin_s2_d = pin_s1_q;
  end

  always_ff @(posedge core_clk) begin
    // reset to the idle pin level, so status bit does not blip after reset
    if (!rstn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
    end
  end

  // ----------------------------------------
  // setup register
  // ----------------------------------------
  // address decode
  assign setup_wr = cmd.valid && cmd.write && (cmd.addr == `SHWD_SETUP_ADDR);

  always_comb begin
    cfg_d = cfg_q;
    if (setup_wr) begin
      // read-only reserved field never stores; bits 7 and 5:4 keep the write
      cfg_d = cmd.data & ~`SHWD_RSVD_RO_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------
  // readback word
  // ----------------------------------------
  // registered, so a read always sees one settled word
  always_comb begin
    rd_d = '0;
    rd_d[15:0] = cfg_q;
    rd_d[`SHWD_ADDR_MSB:`SHWD_ADDR_LSB] = `SHWD_SETUP_ADDR;
    rd_d[`SHWD_FAULT_STAT_BIT] = ~pin_s2_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_q <= `SHWD_SETUP_RESET;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;

  // ----------------------------------------
  // timer state machine
  // ----------------------------------------
  // command restart
  assign kick = setup_wr || (cmd.valid && cfg_q[`SHWD_RESTART_CMD_BIT]);
  // period follows the live select; the setup write also restarts the count, so a shorter one never expires at once
  assign limit = period_cycles(cfg_q[`SHWD_PSEL_MSB:`SHWD_PSEL_LSB]);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      SHWD_OFF: begin
        if (cfg_q[`SHWD_EN_BIT] && !flag_q) begin
          st_d = SHWD_RUN;
        end
      end
      SHWD_RUN: begin
        if (!cfg_q[`SHWD_EN_BIT]) begin
          st_d = SHWD_OFF;
        end else if (expire) begin
          st_d = SHWD_TRIP;
        end
      end
      SHWD_TRIP: begin
        if (!flag_q) begin
          st_d = SHWD_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q <= SHWD_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // expiry decode
  // ----------------------------------------
  // expiry beats a kick in the same cycle, as the period is already spent
  assign expire = (st_q == SHWD_RUN) && cfg_q[`SHWD_EN_BIT] && (cnt_q >= limit - 32'h1);

  // ----------------------------------------
  // period counter
  // ----------------------------------------
  always_comb begin
    cnt_d = '0;
    // only a running, unexpired timer counts; a kick starts over
    if ((st_q == SHWD_RUN) && cfg_q[`SHWD_EN_BIT] && !expire && !kick) begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // fault flag
  // ----------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (flag_clear) begin
      flag_d = 1'b0;
    end
    if (expire) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ----------------------------------------
  // expiry responses
  // ----------------------------------------
  // pulses last one cycle; the code holds until the next expiry
  always_comb begin
    resp_d = resp_q;
    resp_d.load = 1'b0;
    resp_d.soft_reset = 1'b0;
    if (expire) begin
      resp_d.load = cfg_q[`SHWD_CLR_OUT_BIT];
      resp_d.code = clear_code;
      resp_d.soft_reset = cfg_q[`SHWD_SOFT_RST_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      resp_q <= '0;
    end else begin
      resp_q <= resp_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign resp = resp_q;
  assign wd_fault_flag = flag_q;
  // decoded from the one-hot state, no flop of its own
  assign wd_running = (st_q == SHWD_RUN);

endmodule : shwd_watchdog

// *** test/shwd_watchdog_checker.sv ***
// port-level checks of the serial host watchdog
// assumes binding onto shwd_watchdog, one clock domain
`timescale 1ns/100ps
module shwd_watchdog_checker
  import shwd_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rstn, // reset, active low
  input wire shwd_cmd_t cmd, // command
  input wire logic fault_pin_level, // pad level
  input wire logic flag_clear, // clear pulse
  input wire logic [15:0] clear_code, // clear code
  input wire logic [21:0] rd_data, // readback
  input wire shwd_resp_t resp, // responses
  input wire logic wd_fault_flag, // fault flag
  input wire logic wd_running // counting
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_addr_field: assert property (rd_data[20:16] == 5'h0f)
    else $error("address field wrong");
  a_rsvd_zero: assert property (rd_data[15:11] == 5'h00)
    else $error("reserved bits not zero");
  a_resp_match: assert property ($rose(wd_fault_flag) |->
    resp.load == rd_data[10] && resp.soft_reset == rd_data[9])
    else $error("expiry response wrong");
  a_resp_cause: assert property ((resp.load || resp.soft_reset) |->
    $rose(wd_fault_flag)) else $error("response without expiry");
  a_load_pulse: assert property (resp.load |=> !resp.load)
    else $error("load not one cycle");
  a_code_taken: assert property (resp.load |-> resp.code == $past(clear_code))
    else $error("clear code not captured");
  a_flag_sticky: assert property (wd_fault_flag && !flag_clear |=> wd_fault_flag)
    else $error("flag dropped");
  a_flag_clears: assert property (flag_clear && wd_fault_flag |=> !wd_fault_flag)
    else $error("flag not cleared");
  a_fault_halts: assert property (wd_fault_flag |-> !wd_running)
    else $error("running with fault");
  a_pin_status: assert property ($stable(fault_pin_level) [*5] |->
    rd_data[21] == !fault_pin_level) else $error("pin status wrong");
endmodule : shwd_watchdog_checker

bind shwd_watchdog shwd_watchdog_checker u_chk (.core_clk(core_clk), .rstn(rstn),
  .cmd(cmd), .fault_pin_level(fault_pin_level), .flag_clear(flag_clear),
  .clear_code(clear_code), .rd_data(rd_data), .resp(resp),
  .wd_fault_flag(wd_fault_flag), .wd_running(wd_running));

// *** test/shwd_host.sv ***
// host model issuing decoded commands and flag clears
// assumes callers enter tasks between edges; drives at falling edge
`timescale 1ns/100ps
module shwd_host
  import shwd_pkg::*;
(
  input wire logic core_clk, // core clock
  output shwd_cmd_t cmd, // command
  output logic flag_clear // clear pulse
);
  initial begin
    cmd = '0;
    flag_clear = 1'b0;
  end
  task automatic send(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    cmd <= '{1'b1, wr, a, d & 16'h074f};
    @(negedge core_clk);
    cmd <= '0;
  endtask : send
  task automatic clear_flag();
    @(negedge core_clk);
    flag_clear <= 1'b1;
    @(negedge core_clk);
    flag_clear <= 1'b0;
  endtask : clear_flag
endmodule : shwd_host

// *** test/test_serial_host_watchdog.sv ***
// testbench of the serial host watchdog, periods shortened
// assumes shwd_host as command source and the bound checker
`timescale 1ns/100ps
module test_serial_host_watchdog;
  import shwd_pkg::*;
  localparam int MSC = 4;
  logic core_clk, rstn, pin, flag_clear, flag, running;
  logic [15:0] ccode;
  logic [21:0] rd_data;
  shwd_cmd_t cmd;
  shwd_resp_t resp;
  int err_count, total_checks, n;
  int ms[16] = '{1, 5, 10, 25, 50, 100, 250, 500, 750, 1000, 2000, 1000, 1000, 1000, 1000, 1000};
  shwd_watchdog #(.MS_CYCLES(MSC)) dut (.core_clk(core_clk), .rstn(rstn), .cmd(cmd),
    .fault_pin_level(pin), .flag_clear(flag_clear), .clear_code(ccode), .rd_data(rd_data),
    .resp(resp), .wd_fault_flag(flag), .wd_running(running));
  shwd_host host (.core_clk(core_clk), .cmd(cmd), .flag_clear(flag_clear));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // bounded wait, counts edges until the flag is seen
  task automatic wait_flag(input int lim, output int c);
    c = 0;
    while (flag !== 1'b1) begin
      @(posedge core_clk);
      #1;
      c++;
      if (c > lim) begin
        check(22'h0, 22'h1);
        give_verdict();
      end
    end
  endtask : wait_flag
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    pin = 1'b1;
    ccode = 16'h0;
    err_count = 0;
    total_checks = 0;
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    check(rd_data, 22'h0f0009);
    repeat (2) @(negedge core_clk);
    check(rd_data, 22'h0f0009);
    for (int i = 0; i < 16; i++) begin
      if (i inside {[12:14]}) continue;
      ccode = 16'ha500 + 16'(i);
      host.send(1'b1, 5'h0f, 16'h0040 | 16'(i) | (i[0] ? 16'h0400 : 16'h0200));
      wait_flag(ms[i] * MSC + 8, n);
      check(22'(n), 22'(ms[i] * MSC + 1));
      check({resp.load, resp.soft_reset, resp.code}, {i[0], !i[0], ccode});
      if (i < 15) host.send(1'b1, 5'h0f, 16'h0009);
      check(22'({flag, running}), 22'h2);
      if (i < 15) host.clear_flag();
    end
    host.send(1'b1, 5'h0f, 16'h0040);
    repeat (3) @(negedge core_clk);
    check(22'(running), 22'h0);
    host.clear_flag();
    repeat (2) @(negedge core_clk);
    check(22'(running), 22'h1);
    host.send(1'b1, 5'h0f, 16'h0000);
    host.clear_flag();
    host.send(1'b1, 5'h0f, 16'h0140);
    repeat (10) host.send(1'b0, 5'h03, 16'h0000);
    check(22'(flag), 22'h0);
    check(rd_data, 22'h0f0140);
    wait_flag(12, n);
    host.send(1'b1, 5'h0f, 16'h0000);
    host.clear_flag();
    host.send(1'b1, 5'h0f, 16'h0040);
    repeat (5) host.send(1'b0, 5'h03, 16'h0000);
    check(22'(flag), 22'h1);
    pin = 1'b0;
    repeat (4) @(negedge core_clk);
    check(22'(rd_data[21]), 22'h1);
    give_verdict();
  end
endmodule : test_serial_host_watchdog
